// [verilog/ipr_order_pkg.sv]
// package: constants for the internal register access ordering block
`default_nettype none
package ipr_order_pkg;
  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int SCBD_W     = 8;
  localparam int SCBD_LO_W  = 4;
  localparam int ADDR_W     = 4;
  localparam int BUS_W      = 32;
  localparam int GPR_IDX_W  = 5;
  localparam int SHADOW_N   = 8;
  localparam int SHADOW_IDX_W = 3;
  localparam int FP_FLAG_N  = 5;
  localparam int RD_CNT_W   = 4;
  // ------------------------------------------------------------------
  // register map of the software port (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS    = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 4'h4;
  localparam logic [ADDR_W-1:0] EXCSUM_OFS  = 4'h8;
  localparam logic [ADDR_W-1:0] FPCTL_OFS   = 4'hc;
  // ------------------------------------------------------------------
  // fields
  // ------------------------------------------------------------------
  localparam int SHADOW_EN_W    = 2;
  localparam int SHADOW_EN_BIT  = 1;
  localparam logic [SHADOW_EN_W-1:0] CTRL_RESET = 2'h0;
  localparam int STAT_SCBD_LSB  = 0;
  localparam int STAT_LOCK_BIT  = 8;
  localparam int STAT_STALL_BIT = 9;
  localparam int FP_STATUS_LSB  = 52;
  localparam int FP_ENABLE_LSB  = 1;
  // scratch slot that takes the privileged call return address
  localparam logic [SHADOW_IDX_W-1:0] LINK_SLOT = 3'h7;
  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic {LOCK_DEFAULT, LOCK_HELD} lock_state_e;
endpackage : ipr_order_pkg
`default_nettype wire

// [verilog/ipr_access_ordering.sv]
// module: ordering control for internal processor register accesses
`default_nettype none
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module ipr_access_ordering #(
  parameter int NUM_IPR = 4,
  parameter int DATA_W  = 64,
  parameter int AGE_W   = 8
) (
  // clock and reset
  input  wire logic                                    clock,
  input  wire logic                                    reset,
  // software register port
  input  wire logic [ipr_order_pkg::ADDR_W-1:0]        reg_addr,
  input  wire logic [ipr_order_pkg::BUS_W-1:0]         reg_wdata,
  input  wire logic                                    reg_wr,
  input  wire logic                                    reg_rd,
  output logic      [ipr_order_pkg::BUS_W-1:0]         reg_rdata,
  // queue entry of internal register ops and memory ops
  input  wire logic                                    enter_valid,
  input  wire logic [ipr_order_pkg::SCBD_W-1:0]        enter_mask,
  input  wire logic                                    enter_is_writer,
  input  wire logic                                    enter_same_block,
  output logic                                         enter_stall,
  // scoreboard release by writers
  input  wire logic [ipr_order_pkg::SCBD_W-1:0]        wr_issue_mask,
  input  wire logic [ipr_order_pkg::SCBD_W-1:0]        wr_retire_mask,
  input  wire logic [ipr_order_pkg::SCBD_W-1:0]        wr_abort_mask,
  // readers leaving the queue
  input  wire logic                                    rd_done,
  input  wire logic [ipr_order_pkg::SCBD_W-1:0]        rd_done_mask,
  // explicit register write and read
  input  wire logic                                    ipr_wr_exec,
  input  wire logic [$clog2(NUM_IPR)-1:0]              ipr_wr_idx,
  input  wire logic [DATA_W-1:0]                       ipr_wr_data,
  input  wire logic                                    ipr_wr_retire,
  input  wire logic                                    ipr_wr_abort,
  input  wire logic [ipr_order_pkg::SCBD_W-1:0]        ipr_wr_group,
  output logic                                         ipr_wr_retire_ok,
  input  wire logic                                    ipr_rd_req,
  input  wire logic [$clog2(NUM_IPR)-1:0]              ipr_rd_idx,
  output logic      [DATA_W-1:0]                       ipr_rd_data,
  // issue holds from memory unit
  input  wire logic                                    store_bubble_busy,
  input  wire logic                                    load_bubble_busy,
  output logic                                         ipr_op_issue_hold,
  output logic                                         load_issue_hold,
  output logic                                         mem_op_issue_hold,
  // exception-written register
  input  wire logic                                    exc_valid,
  input  wire logic [AGE_W-1:0]                        exc_age,
  input  wire logic [DATA_W-1:0]                       exc_info,
  input  wire logic                                    kill_valid,
  input  wire logic [AGE_W-1:0]                        kill_age,
  output logic      [DATA_W-1:0]                       exc_reg_q,
  output logic                                         exc_locked,
  // stalling privileged return
  input  wire logic                                    priv_ret_enter,
  input  wire logic                                    priv_ret_stall_bit,
  input  wire logic                                    priv_ret_done,
  output logic                                         fetch_stall,
  // scratch overlay
  input  wire logic                                    privileged_code_mode,
  input  wire logic [ipr_order_pkg::GPR_IDX_W-1:0]     gpr_idx,
  input  wire logic                                    gpr_wr,
  input  wire logic [DATA_W-1:0]                       gpr_wdata,
  output logic                                         shadow_hit,
  output logic      [DATA_W-1:0]                       shadow_rdata,
  input  wire logic                                    priv_call_valid,
  input  wire logic [DATA_W-1:0]                       priv_call_ret_addr,
  // floating-point control register
  input  wire logic                                    fp_exc_valid,
  input  wire logic [ipr_order_pkg::FP_FLAG_N-1:0]     fp_exc_flags,
  output logic                                         arithmetic_trap,
  input  wire logic                                    fp_ctl_read_op,
  output logic      [DATA_W-1:0]                       fp_ctl_rdata,
  input  wire logic                                    fp_ctl_write_op,
  input  wire logic [DATA_W-1:0]                       fp_ctl_wdata,
  input  wire logic                                    fp_ctl_write_retire,
  output logic                                         fp_ctl_trap
);
  import ipr_order_pkg::*;

  // ----------------------------------------------------------------------
  // explicit register pairs
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0]          stage_q [NUM_IPR];
  logic [DATA_W-1:0]          commit_q [NUM_IPR];
  logic [$clog2(NUM_IPR)-1:0] pend_idx_q;
  logic                       pend_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pend_q     <= 1'b0;
      pend_idx_q <= '0;
    end else if (ipr_wr_exec) begin
      pend_q     <= 1'b1;
      pend_idx_q <= ipr_wr_idx;
    end else if (ipr_wr_abort || (ipr_wr_retire && ipr_wr_retire_ok)) begin
      pend_q     <= 1'b0;
    end
  end

  // one staging register per index; indices that share staging must share bits
  generate
    for (genvar i = 0; i < NUM_IPR; i++) begin : g_pair
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          stage_q[i]  <= '0;
          commit_q[i] <= '0;
        end else begin
          if (ipr_wr_exec && ipr_wr_idx == i)
            stage_q[i] <= ipr_wr_data;
          if (pend_q && pend_idx_q == i && ipr_wr_retire && ipr_wr_retire_ok)
            commit_q[i] <= stage_q[i];
        end
      end
    end
  endgenerate

  // readers only ever see the committed copy
  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      ipr_rd_data <= '0;
    else if (ipr_rd_req)
      ipr_rd_data <= commit_q[ipr_rd_idx];
  end

  // ----------------------------------------------------------------------
  // scoreboard and dependent reader counts
  // ----------------------------------------------------------------------
  logic [SCBD_W-1:0]   sb_q;
  logic [SCBD_W-1:0]   sb_clr;
  logic [SCBD_W-1:0]   rd_busy;
  logic [RD_CNT_W-1:0] rd_cnt_q [SCBD_W];
  logic                enter_take;
  logic                check_blocked;

  // low group frees at issue, high group at retire; aborts free both
  assign sb_clr = {wr_retire_mask[SCBD_W-1:SCBD_LO_W], wr_issue_mask[SCBD_LO_W-1:0]}
                | wr_abort_mask;
  // inside one fetch block the check is skipped
  assign check_blocked = |(enter_mask & (sb_q | rd_busy)) && !enter_same_block;
  assign enter_stall   = enter_valid && check_blocked;
  assign enter_take    = enter_valid && !check_blocked;

  generate
    for (genvar b = 0; b < SCBD_W; b++) begin : g_sb
      assign rd_busy[b] = rd_cnt_q[b] != '0;
      always_ff @(posedge clock or posedge reset) begin
        if (reset)
          sb_q[b] <= 1'b0;
        else if (enter_take && enter_is_writer && enter_mask[b])
          sb_q[b] <= 1'b1; // set wins over release
        else if (sb_clr[b])
          sb_q[b] <= 1'b0;
      end
      always_ff @(posedge clock or posedge reset) begin
        if (reset)
          rd_cnt_q[b] <= '0;
        else if ((enter_take && !enter_is_writer && enter_mask[b])
                 && !(rd_done && rd_done_mask[b]))
          rd_cnt_q[b] <= rd_cnt_q[b] + 1'b1;
        else if (!(enter_take && !enter_is_writer && enter_mask[b])
                 && rd_done && rd_done_mask[b] && rd_busy[b])
          rd_cnt_q[b] <= rd_cnt_q[b] - 1'b1;
      end
    end
  endgenerate

  // a writer waits on readers that hold any of its group's bits
  assign ipr_wr_retire_ok = !(|(ipr_wr_group & rd_busy));
  // translation writes hold later memory ops through the low bits
  assign mem_op_issue_hold = |sb_q[SCBD_LO_W-1:0];
  assign ipr_op_issue_hold = store_bubble_busy;
  assign load_issue_hold   = load_bubble_busy;

  // ----------------------------------------------------------------------
  // exception-written register with lock
  // ----------------------------------------------------------------------
  lock_state_e      lock_q;
  logic [AGE_W-1:0] lock_age_q;
  logic             exc_take;

  // smaller age is older
  assign exc_take   = exc_valid && (lock_q == LOCK_DEFAULT || exc_age < lock_age_q);
  assign exc_locked = lock_q == LOCK_HELD;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lock_q     <= LOCK_DEFAULT;
      lock_age_q <= '0;
      exc_reg_q  <= '0;
    end else begin
      case (lock_q)
        LOCK_DEFAULT: begin
          if (exc_valid) begin
            exc_reg_q  <= exc_info;
            lock_age_q <= exc_age;
            lock_q     <= LOCK_HELD;
          end
        end
        LOCK_HELD: begin
          if (kill_valid && kill_age <= lock_age_q)
            lock_q <= LOCK_DEFAULT;
          else if (exc_take) begin
            exc_reg_q  <= exc_info;
            lock_age_q <= exc_age;
          end
        end
        default: lock_q <= LOCK_DEFAULT;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // stalling privileged return
  // ----------------------------------------------------------------------
  logic ret_stall_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      ret_stall_q <= 1'b0;
    else if (priv_ret_enter && priv_ret_stall_bit)
      ret_stall_q <= 1'b1;
    else if (priv_ret_done)
      ret_stall_q <= 1'b0;
  end
  assign fetch_stall = ret_stall_q;

  // ----------------------------------------------------------------------
  // scratch overlay registers
  // ----------------------------------------------------------------------
  logic [SHADOW_EN_W-1:0]  shadow_en_q;
  logic [DATA_W-1:0]       shadow_q [SHADOW_N];
  logic [SHADOW_IDX_W-1:0] shadow_slot;
  logic                    shadow_range;

  // overlaid integer registers 4..7 and 20..23
  assign shadow_range = (gpr_idx[4:2] == 3'h1) || (gpr_idx[4:2] == 3'h5);
  assign shadow_slot  = {gpr_idx[4], gpr_idx[1:0]};
  assign shadow_hit   = privileged_code_mode && shadow_en_q[SHADOW_EN_BIT]
                        && shadow_range;

  generate
    for (genvar s = 0; s < SHADOW_N; s++) begin : g_shadow
      always_ff @(posedge clock or posedge reset) begin
        if (reset)
          shadow_q[s] <= '0;
        else if (priv_call_valid && s == LINK_SLOT)
          shadow_q[s] <= priv_call_ret_addr;
        else if (gpr_wr && shadow_hit && shadow_slot == s)
          shadow_q[s] <= gpr_wdata;
      end
    end
  endgenerate

  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      shadow_rdata <= '0;
    else
      shadow_rdata <= shadow_q[shadow_slot];
  end

  // ----------------------------------------------------------------------
  // floating-point control register
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0]    fp_stage_q;
  logic [DATA_W-1:0]    fp_commit_q;
  logic [FP_FLAG_N-1:0] fp_status;
  logic [FP_FLAG_N-1:0] fp_enable;
  logic [DATA_W-1:0]    exc_sum_q;
  logic                 fp_trap_need;

  assign fp_status    = fp_commit_q[FP_STATUS_LSB +: FP_FLAG_N];
  assign fp_enable    = fp_commit_q[FP_ENABLE_LSB +: FP_FLAG_N];
  // status flags are only set by the handler, so a clear flag must trap
  assign fp_trap_need = |(fp_exc_flags & (~fp_status | fp_enable));

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fp_stage_q  <= '0;
      fp_commit_q <= '0;
      fp_ctl_trap <= 1'b0;
    end else begin
      fp_ctl_trap <= fp_ctl_write_op;
      if (fp_ctl_write_op)
        fp_stage_q <= fp_ctl_wdata;
      if (fp_ctl_write_retire)
        fp_commit_q <= fp_stage_q;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      arithmetic_trap <= 1'b0;
      exc_sum_q  <= '0;
    end else begin
      arithmetic_trap <= fp_exc_valid && fp_trap_need;
      if (fp_exc_valid && fp_trap_need)
        exc_sum_q <= {{(DATA_W-FP_FLAG_N){1'b0}}, fp_exc_flags};
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      fp_ctl_rdata <= '0;
    else if (fp_ctl_read_op)
      fp_ctl_rdata <= fp_commit_q;
  end

  // ----------------------------------------------------------------------
  // software register port
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      shadow_en_q <= CTRL_RESET;
    else if (reg_wr && reg_addr == CTRL_OFS)
      shadow_en_q <= reg_wdata[SHADOW_EN_W-1:0];
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      reg_rdata <= '0;
    else if (reg_rd) begin
      case (reg_addr)
        CTRL_OFS:   reg_rdata <= {{(BUS_W-SHADOW_EN_W){1'b0}}, shadow_en_q};
        STATUS_OFS: reg_rdata <= {22'h0, ret_stall_q, exc_locked, sb_q};
        EXCSUM_OFS: reg_rdata <= exc_sum_q[BUS_W-1:0];
        FPCTL_OFS:  reg_rdata <= fp_commit_q[BUS_W-1:0];
        default:    reg_rdata <= '0;
      endcase
    end else
      reg_rdata <= '0;
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_commit_on_retire;
    @(posedge clock) disable iff (reset)
      pend_q && ipr_wr_retire && ipr_wr_retire_ok
      |=> commit_q[$past(pend_idx_q)] == $past(stage_q[pend_idx_q]);
  endproperty
  a_commit_on_retire: assert property (p_commit_on_retire) else $error("commit missed at retire");

  property p_commit_hold;
    @(posedge clock) disable iff (reset)
      !(ipr_wr_retire && ipr_wr_retire_ok) |=> $stable(commit_q[0]);
  endproperty
  a_commit_hold: assert property (p_commit_hold) else $error("commit changed without retire");

  property p_read_committed;
    @(posedge clock) disable iff (reset)
      ipr_rd_req |=> ipr_rd_data == $past(commit_q[ipr_rd_idx]);
  endproperty
  a_read_committed: assert property (p_read_committed) else $error("read not from commit");

  property p_wr_waits_reader;
    @(posedge clock) disable iff (reset)
      |(ipr_wr_group & rd_busy) |-> !ipr_wr_retire_ok;
  endproperty
  a_wr_waits_reader: assert property (p_wr_waits_reader) else $error("writer retire with reader");

  property p_lock_on_exc;
    @(posedge clock) disable iff (reset)
      lock_q == LOCK_DEFAULT && exc_valid |=> lock_q == LOCK_HELD && exc_reg_q == $past(exc_info);
  endproperty
  a_lock_on_exc: assert property (p_lock_on_exc) else $error("exception did not lock");

  property p_locked_younger;
    @(posedge clock) disable iff (reset)
      lock_q == LOCK_HELD && exc_valid && exc_age >= lock_age_q && !kill_valid
      |=> $stable(exc_reg_q);
  endproperty
  a_locked_younger: assert property (p_locked_younger) else $error("younger overwrote lock");

  property p_kill_unlock;
    @(posedge clock) disable iff (reset)
      lock_q == LOCK_HELD && kill_valid && kill_age <= lock_age_q |=> lock_q == LOCK_DEFAULT;
  endproperty
  a_kill_unlock: assert property (p_kill_unlock) else $error("kill did not unlock");

  property p_ret_stall;
    @(posedge clock) disable iff (reset)
      (priv_ret_enter && priv_ret_stall_bit) || (fetch_stall && !priv_ret_done)
      |=> fetch_stall;
  endproperty
  a_ret_stall: assert property (p_ret_stall) else $error("stall dropped early");

  property p_entry_stall;
    @(posedge clock) disable iff (reset)
      enter_valid && !enter_same_block && |(enter_mask & sb_q) |-> enter_stall;
  endproperty
  a_entry_stall: assert property (p_entry_stall) else $error("entry with set bits");

  property p_low_clear;
    @(posedge clock) disable iff (reset)
      wr_issue_mask[0] && !(enter_take && enter_is_writer && enter_mask[0]) |=> !sb_q[0];
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("low bit not cleared at issue");

  property p_fp_trap;
    @(posedge clock) disable iff (reset)
      fp_ctl_write_op |=> fp_ctl_trap && fp_stage_q == $past(fp_ctl_wdata);
  endproperty
  a_fp_trap: assert property (p_fp_trap) else $error("fp control write no trap");

  property p_shadow_gate;
    @(posedge clock) disable iff (reset)
      shadow_hit |-> privileged_code_mode && shadow_en_q[SHADOW_EN_BIT];
  endproperty
  a_shadow_gate: assert property (p_shadow_gate) else $error("overlay outside mode");

  property p_link_slot;
    @(posedge clock) disable iff (reset)
      priv_call_valid |=> shadow_q[LINK_SLOT] == $past(priv_call_ret_addr);
  endproperty
  a_link_slot: assert property (p_link_slot) else $error("link slot not written");

endmodule : ipr_access_ordering // ipr_access_ordering
`default_nettype wire

// [tb/ipr_access_ordering_tb_top.sv]
// testbench: directed checks of the internal register access ordering block
`default_nettype none
module ipr_access_ordering_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ipr_order_pkg::*;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic clock, reset, reg_wr, reg_rd, enter_valid, enter_is_writer, enter_same_block;
  logic enter_stall, rd_done, ipr_wr_exec, ipr_wr_retire, ipr_wr_abort, ipr_wr_retire_ok;
  logic ipr_rd_req, store_bubble_busy, load_bubble_busy, ipr_op_issue_hold, load_issue_hold;
  logic mem_op_issue_hold, exc_valid, kill_valid, exc_locked, priv_ret_enter;
  logic priv_ret_stall_bit, priv_ret_done, fetch_stall, privileged_code_mode, gpr_wr;
  logic shadow_hit, priv_call_valid, fp_exc_valid, arithmetic_trap, fp_ctl_read_op;
  logic fp_ctl_write_op, fp_ctl_write_retire, fp_ctl_trap;
  logic [ADDR_W-1:0] reg_addr;
  logic [BUS_W-1:0]  reg_wdata, reg_rdata, rv;
  logic [SCBD_W-1:0] enter_mask, wr_issue_mask, wr_retire_mask, wr_abort_mask;
  logic [SCBD_W-1:0] rd_done_mask, ipr_wr_group;
  logic [1:0]        ipr_wr_idx, ipr_rd_idx;
  logic [63:0]       ipr_wr_data, ipr_rd_data, exc_info, exc_reg_q, gpr_wdata, shadow_rdata;
  logic [63:0]       priv_call_ret_addr, fp_ctl_rdata, fp_ctl_wdata;
  logic [7:0]        exc_age, kill_age;
  logic [4:0]        gpr_idx, fp_exc_flags;
  int                err_total, n_checks;

  ipr_access_ordering u_ipr_access_ordering (.*);

  always #4 clock = ~clock;
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clock); reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clock); reg_wr <= 1'b0;
  endtask
  task automatic iprd(input logic [1:0] i, input logic [63:0] exp, input string nm);
    @(posedge clock); ipr_rd_req <= 1'b1; ipr_rd_idx <= i;
    @(posedge clock); ipr_rd_req <= 1'b0;
    #1 chk(nm, ipr_rd_data, exp);
  endtask
  task automatic exc(input logic [7:0] age, input logic [63:0] info, input logic kill);
    @(posedge clock); exc_valid <= !kill; kill_valid <= kill; exc_age <= age;
    kill_age <= age; exc_info <= info;
    @(posedge clock); exc_valid <= 1'b0; kill_valid <= 1'b0;
    #1;
  endtask
  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under a thousand cycles
  initial begin
    #(8 * 5000);
    err_total++;
    wrap_up();
  end
  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    {clock, reg_wr, reg_rd, enter_valid, enter_is_writer, enter_same_block, rd_done} = '0;
    {ipr_wr_exec, ipr_wr_retire, ipr_wr_abort, ipr_rd_req, store_bubble_busy} = '0;
    {load_bubble_busy, exc_valid, kill_valid, priv_ret_enter, priv_ret_stall_bit} = '0;
    {priv_ret_done, privileged_code_mode, gpr_wr, priv_call_valid, fp_exc_valid} = '0;
    {fp_ctl_read_op, fp_ctl_write_op, fp_ctl_write_retire, reg_addr, reg_wdata} = '0;
    {enter_mask, wr_issue_mask, wr_retire_mask, wr_abort_mask, rd_done_mask} = '0;
    {ipr_wr_group, ipr_wr_idx, ipr_rd_idx, ipr_wr_data, exc_info, gpr_wdata} = '0;
    {priv_call_ret_addr, fp_ctl_wdata, exc_age, kill_age, gpr_idx, fp_exc_flags} = '0;
    err_total = 0; n_checks = 0; reset = 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rd(STATUS_OFS, rv); chk("status_rst", rv, 0);
    rd(CTRL_OFS, rv); chk("ctrl_rst", rv, CTRL_RESET);
    rd(4'h2, rv); chk("unmapped", rv, 0);
    iprd(2'h1, 0, "ipr_rst");
    // staged write is invisible to readers until it retires
    @(posedge clock); ipr_wr_exec <= 1'b1; ipr_wr_idx <= 2'h1;
    ipr_wr_data <= 64'h1234_5678_9abc_def0;
    @(posedge clock); ipr_wr_exec <= 1'b0;
    iprd(2'h1, 0, "ipr_before_retire");
    // a pending reader on bit 5 holds off retirement of a writer in that group
    @(posedge clock); enter_valid <= 1'b1; enter_mask <= 8'h20;
    @(posedge clock); enter_valid <= 1'b0; ipr_wr_group <= 8'h20;
    #1 chk("retire_ok_reader", ipr_wr_retire_ok, 1'b0);
    @(posedge clock); rd_done <= 1'b1; rd_done_mask <= 8'h20;
    @(posedge clock); rd_done <= 1'b0;
    #1 chk("retire_ok_free", ipr_wr_retire_ok, 1'b1);
    @(posedge clock); ipr_wr_retire <= 1'b1;
    @(posedge clock); ipr_wr_retire <= 1'b0; ipr_wr_group <= 8'h00;
    iprd(2'h1, 64'h1234_5678_9abc_def0, "ipr_after_retire");
    // scoreboard: set, refuse, same-block bypass, staged release
    @(posedge clock); enter_valid <= 1'b1; enter_mask <= 8'h11; enter_is_writer <= 1'b1;
    @(posedge clock); enter_mask <= 8'h01; enter_is_writer <= 1'b0;
    #1 chk("mem_hold", mem_op_issue_hold, 1'b1);
    chk("enter_stall", enter_stall, 1'b1);
    @(posedge clock); enter_same_block <= 1'b1; enter_mask <= 8'h10;
    #1 chk("same_block", enter_stall, 1'b0);
    @(posedge clock); enter_valid <= 1'b0; enter_same_block <= 1'b0; wr_issue_mask <= 8'h01;
    @(posedge clock); wr_issue_mask <= 8'h00;
    rd(STATUS_OFS, rv); chk("sb_after_issue", rv, 32'h10);
    chk("mem_hold_clr", mem_op_issue_hold, 1'b0);
    @(posedge clock); wr_retire_mask <= 8'h10;
    @(posedge clock); wr_retire_mask <= 8'h00;
    rd(STATUS_OFS, rv); chk("sb_after_retire", rv, 0);
    // memory-unit busy indications
    @(posedge clock); store_bubble_busy <= 1'b1;
    #1 chk("st_hold", ipr_op_issue_hold, 1'b1);
    chk("ld_free", load_issue_hold, 1'b0);
    @(posedge clock); store_bubble_busy <= 1'b0; load_bubble_busy <= 1'b1;
    #1 chk("ld_hold", load_issue_hold, 1'b1);
    chk("st_free", ipr_op_issue_hold, 1'b0);
    // exception-written register lock
    exc(8'd5, 64'h55, 1'b0); chk("lock_set", exc_locked, 1'b1);
    chk("lock_val", exc_reg_q, 64'h55);
    exc(8'd7, 64'h77, 1'b0); chk("lock_younger", exc_reg_q, 64'h55);
    exc(8'd3, 64'h33, 1'b0); chk("lock_older", exc_reg_q, 64'h33);
    rd(STATUS_OFS, rv); chk("status_lock", rv, 32'h100);
    exc(8'd3, 64'h0, 1'b1); chk("lock_kill", exc_locked, 1'b0);
    // stalling privileged return
    @(posedge clock); priv_ret_enter <= 1'b1; priv_ret_stall_bit <= 1'b1;
    @(posedge clock); priv_ret_enter <= 1'b0;
    #1 chk("fetch_stall", fetch_stall, 1'b1);
    @(posedge clock); priv_ret_done <= 1'b1;
    @(posedge clock); priv_ret_done <= 1'b0; priv_ret_stall_bit <= 1'b0;
    #1 chk("fetch_go", fetch_stall, 1'b0);
    // scratch overlay gating
    wr(CTRL_OFS, 32'h2);
    @(posedge clock); privileged_code_mode <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      @(posedge clock); gpr_idx <= 5'(i);
      #1 chk("shadow_map", shadow_hit, (i inside {[4:7], [20:23]}));
    end
    @(posedge clock); privileged_code_mode <= 1'b0; gpr_idx <= 5'd4;
    #1 chk("shadow_user", shadow_hit, 1'b0);
    wr(CTRL_OFS, 32'h1);
    @(posedge clock); privileged_code_mode <= 1'b1;
    #1 chk("shadow_off", shadow_hit, 1'b0);
    wr(CTRL_OFS, 32'h2);
    @(posedge clock); priv_call_valid <= 1'b1; priv_call_ret_addr <= 64'h2001; gpr_idx <= 5'd23;
    @(posedge clock); priv_call_valid <= 1'b0;
    @(posedge clock); #1 chk("link_slot", shadow_rdata, 64'h2001);
    @(posedge clock); gpr_wr <= 1'b1; gpr_idx <= 5'd5; gpr_wdata <= 64'h55aa;
    @(posedge clock); gpr_wr <= 1'b0;
    @(posedge clock); #1 chk("shadow_wr", shadow_rdata, 64'h55aa);
    // fp control: trap on write, commit at retire, trap policy
    @(posedge clock); fp_exc_valid <= 1'b1; fp_exc_flags <= 5'h02;
    @(posedge clock); fp_exc_valid <= 1'b0;
    #1 chk("arithmetic_trap_handler_flag_clr", arithmetic_trap, 1'b1);
    @(posedge clock); fp_ctl_write_op <= 1'b1; fp_ctl_wdata <= 64'h01f0_0000_0000_0002;
    @(posedge clock); fp_ctl_write_op <= 1'b0; fp_ctl_read_op <= 1'b1;
    #1 chk("fp_trap", fp_ctl_trap, 1'b1);
    @(posedge clock); fp_ctl_read_op <= 1'b0;
    #1 chk("fp_staged", fp_ctl_rdata, 0);
    @(posedge clock); fp_ctl_write_retire <= 1'b1;
    @(posedge clock); fp_ctl_write_retire <= 1'b0; fp_ctl_read_op <= 1'b1;
    @(posedge clock); fp_ctl_read_op <= 1'b0;
    #1 chk("fp_commit", fp_ctl_rdata, 64'h01f0_0000_0000_0002);
    @(posedge clock); fp_exc_valid <= 1'b1; fp_exc_flags <= 5'h02;
    @(posedge clock); fp_exc_valid <= 1'b0;
    #1 chk("arithmetic_trap_handler_quiet", arithmetic_trap, 1'b0);
    @(posedge clock); fp_exc_valid <= 1'b1; fp_exc_flags <= 5'h01;
    @(posedge clock); fp_exc_valid <= 1'b0;
    #1 chk("arithmetic_trap_handler_enabled", arithmetic_trap, 1'b1);
    rd(EXCSUM_OFS, rv); chk("exc_sum", rv, 32'h1);
    wrap_up();
  end
endmodule // ipr_access_ordering_tb_top
`default_nettype wire
